// [dwb_params.svh]
// offsets, field positions and reset values for the window and blink control block
`ifndef DWB_PARAMS_SVH
`define DWB_PARAMS_SVH

// ****************************************************************
// register byte addresses on the host address bus
// ****************************************************************
`define DWB_ADDR_W            17
`define DWB_OFS_WIN_CTRL      17'h1ff80
`define DWB_OFS_WSTART_LO     17'h1ff81
`define DWB_OFS_WSTART_HI     17'h1ff82
`define DWB_OFS_FSTART_LO     17'h1ff83
`define DWB_OFS_FSTART_HI     17'h1ff84
`define DWB_OFS_WIDTH_LO      17'h1ff85
`define DWB_OFS_WIDTH_HI      17'h1ff86
`define DWB_OFS_HEIGHT_LO     17'h1ff87
`define DWB_OFS_HEIGHT_HI     17'h1ff88
`define DWB_OFS_BLINK_IDX     17'h1ff89
`define DWB_OFS_BLINK_PER     17'h1ff8a
`define DWB_OFS_CLK_SRC_DIV   17'h1ff8b

// ****************************************************************
// field positions and writable masks
// ****************************************************************
`define DWB_CTRL_WIN_EN       4
`define DWB_CTRL_FLOAT        3
`define DWB_CTRL_BLINK        1
`define DWB_CTRL_INVERT       0
`define DWB_CTRL_MASK         8'h1b
`define DWB_WIDTH_HI_MASK     8'h01
`define DWB_HEIGHT_HI_MASK    8'h03
`define DWB_CLK_SRC_BIT       7
`define DWB_CLK_DIV_MSB       6

// ****************************************************************
// widths and reset values
// ****************************************************************
`define DWB_WIDTH_BITS        9
`define DWB_HEIGHT_BITS       10
`define DWB_WADDR_BITS        16
`define DWB_RESET_BYTE        8'h00
`define DWB_LUT_ENTRIES       256
`define DWB_LUT_BITS          4

`endif

// [dwb_pkg.sv]
// types shared by the window and blink control block
`include "dwb_params.svh"

package dwb_pkg;

  // ****************************************************************
  // window fetch sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b01,
    FETCH_RUN  = 2'b10
  } fetch_state_t;

  // ****************************************************************
  // complete state of the top module
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                    ctrl;
    logic [`DWB_WADDR_BITS-1:0]    wstart;
    logic [`DWB_WADDR_BITS-1:0]    fstart;
    logic [`DWB_WIDTH_BITS-1:0]    width;
    logic [`DWB_HEIGHT_BITS-1:0]   height;
    logic [7:0]                    blink_idx;
    logic [7:0]                    blink_per;
    logic [7:0]                    clk_sel;
    logic [7:0]                    rd_data;
    fetch_state_t                  state;
    logic [`DWB_WIDTH_BITS-1:0]    word_cnt;
    logic [`DWB_HEIGHT_BITS-1:0]   line_cnt;
    logic [`DWB_WADDR_BITS-1:0]    line_base;
    logic [`DWB_WADDR_BITS-1:0]    addr;
    logic                          done;
    logic [7:0]                    blink_cnt;
    logic                          blink_phase;
    logic [7:0]                    div_cnt;
    logic                          tick;
    logic                          sel_blink;
    logic                          sel_inv;
  } dwb_state_t;

endpackage

// [colour_lookup_table.sv]
// three colour lookup tables, one per primary, with one write and one read port
`timescale 1ns/10ps
`default_nettype none
`include "dwb_params.svh"

module colour_lookup_table #(
  parameter int ENTRIES = `DWB_LUT_ENTRIES,
  parameter int BITS    = `DWB_LUT_BITS
) (
  input  wire logic                       clk,      // block clock
  input  wire logic                       we,       // write all three tables
  input  wire logic [$clog2(ENTRIES)-1:0] waddr,    // write index
  input  wire logic [3*BITS-1:0]          wdata,    // red, green, blue
  input  wire logic [$clog2(ENTRIES)-1:0] raddr,    // read index
  output logic      [3*BITS-1:0]          rdata     // registered colour
);

  // ****************************************************************
  // one table per colour
  // ****************************************************************
  // no reset on the arrays so they map onto plain ram
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_col
      logic [BITS-1:0] mem [ENTRIES];
      always_ff @(posedge clk) begin
        if (we) begin
          mem[waddr] <= wdata[c*BITS +: BITS];
        end
        rdata[c*BITS +: BITS] <= mem[raddr];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [display_window_blink_control.sv]
// window area registers, window fetch sequencer, blink timer and pixel path
`timescale 1ns/10ps
`default_nettype none
`include "dwb_params.svh"

module display_window_blink_control (
  input  wire logic                        CLOCK,        // 50 MHz block clock
  input  wire logic                        RSTN,         // async reset, active low
  input  wire logic                        CS_N,         // register select, active low
  input  wire logic [`DWB_ADDR_W-1:0]      ADDR,         // host byte address
  input  wire logic                        WR_STB,       // write strobe, one cycle
  input  wire logic                        RD_STB,       // read strobe, one cycle
  input  wire logic [7:0]                  WR_DATA,      // write byte
  output logic      [7:0]                  RD_DATA,      // read byte, next cycle
  input  wire logic                        CLK_DIV2,     // extra divide by two
  output logic                             CLK_SRC_BUS,  // 1: bus clock source
  output logic                             OP_CLK_TICK,  // operating clock tick
  input  wire logic                        FRAME_START,  // frame begins, pulse
  output logic                             FETCH_VALID,  // window fetch request
  input  wire logic                        FETCH_READY,  // memory took the address
  output logic      [`DWB_WADDR_BITS-1:0]  FETCH_ADDR,   // word address to fetch
  output logic                             FETCH_FLOAT,  // fetch is from float buffer
  output logic                             FETCH_DONE,   // last window word taken
  input  wire logic                        LUT_WE,       // colour table write
  input  wire logic [7:0]                  LUT_WADDR,    // colour table index
  input  wire logic [11:0]                 LUT_WDATA,    // red, green, blue
  input  wire logic [7:0]                  PIX_INDEX,    // pixel colour index
  input  wire logic                        PIX_IN_WIN,   // pixel lies in window
  output logic      [11:0]                 PIX_RGB,      // colour, one cycle later
  output logic                             BLINK_PHASE   // 1 while blink colour shown
);

  // ****************************************************************
  // state and decoded controls
  // ****************************************************************
  dwb_pkg::dwb_state_t s_r;
  dwb_pkg::dwb_state_t s_nxt;
  logic                win_en;
  logic                float_en;
  logic                blink_en;
  logic                inv_en;
  logic                wr;
  logic [7:0]          div_lim;
  logic [7:0]          lut_idx;
  logic [11:0]         lut_rgb;

  // mode bits only count while window features are on
  assign win_en   = s_r.ctrl[`DWB_CTRL_WIN_EN];
  assign float_en = win_en & s_r.ctrl[`DWB_CTRL_FLOAT];
  assign blink_en = win_en & s_r.ctrl[`DWB_CTRL_BLINK];
  assign inv_en   = win_en & s_r.ctrl[`DWB_CTRL_INVERT];
  assign wr       = ~CS_N & WR_STB;

  // limit is the divide value, doubled plus one when the extra halving is on, so the tick period doubles
  assign div_lim = CLK_DIV2 ? {s_r.clk_sel[`DWB_CLK_DIV_MSB:0], 1'b1}
                            : {1'b0, s_r.clk_sel[`DWB_CLK_DIV_MSB:0]};

  // blink phase swaps in the blink entry for window pixels
  assign lut_idx = (PIX_IN_WIN & blink_en & s_r.blink_phase) ? s_r.blink_idx : PIX_INDEX;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;

    // register writes; reserved bits are forced to zero
    if (wr) begin
      case (ADDR)
        `DWB_OFS_WIN_CTRL:    s_nxt.ctrl           = WR_DATA & `DWB_CTRL_MASK;
        `DWB_OFS_WSTART_LO:   s_nxt.wstart[7:0]    = WR_DATA;
        `DWB_OFS_WSTART_HI:   s_nxt.wstart[15:8]   = WR_DATA;
        `DWB_OFS_FSTART_LO:   s_nxt.fstart[7:0]    = WR_DATA;
        `DWB_OFS_FSTART_HI:   s_nxt.fstart[15:8]   = WR_DATA;
        `DWB_OFS_WIDTH_LO:    s_nxt.width[7:0]     = WR_DATA;
        `DWB_OFS_WIDTH_HI:    s_nxt.width[8]       = WR_DATA[0];
        `DWB_OFS_HEIGHT_LO:   s_nxt.height[7:0]    = WR_DATA;
        `DWB_OFS_HEIGHT_HI:   s_nxt.height[9:8]    = WR_DATA[1:0];
        `DWB_OFS_BLINK_IDX:   s_nxt.blink_idx      = WR_DATA;
        `DWB_OFS_BLINK_PER:   s_nxt.blink_per      = WR_DATA;
        `DWB_OFS_CLK_SRC_DIV: s_nxt.clk_sel        = WR_DATA;
        default: begin
        end
      endcase
    end

    // register reads; unmapped addresses return zero
    if (~CS_N & RD_STB) begin
      case (ADDR)
        `DWB_OFS_WIN_CTRL:    s_nxt.rd_data = s_r.ctrl;
        `DWB_OFS_WSTART_LO:   s_nxt.rd_data = s_r.wstart[7:0];
        `DWB_OFS_WSTART_HI:   s_nxt.rd_data = s_r.wstart[15:8];
        `DWB_OFS_FSTART_LO:   s_nxt.rd_data = s_r.fstart[7:0];
        `DWB_OFS_FSTART_HI:   s_nxt.rd_data = s_r.fstart[15:8];
        `DWB_OFS_WIDTH_LO:    s_nxt.rd_data = s_r.width[7:0];
        `DWB_OFS_WIDTH_HI:    s_nxt.rd_data = {7'h00, s_r.width[8]} & `DWB_WIDTH_HI_MASK;
        `DWB_OFS_HEIGHT_LO:   s_nxt.rd_data = s_r.height[7:0];
        `DWB_OFS_HEIGHT_HI:   s_nxt.rd_data = {6'h00, s_r.height[9:8]} & `DWB_HEIGHT_HI_MASK;
        `DWB_OFS_BLINK_IDX:   s_nxt.rd_data = s_r.blink_idx;
        `DWB_OFS_BLINK_PER:   s_nxt.rd_data = s_r.blink_per;
        `DWB_OFS_CLK_SRC_DIV: s_nxt.rd_data = s_r.clk_sel;
        default:              s_nxt.rd_data = `DWB_RESET_BYTE;
      endcase
    end

    // operating clock tick: every cycle on the pin source, divided on the bus source
    if (!s_r.clk_sel[`DWB_CLK_SRC_BIT]) begin
      s_nxt.div_cnt = 8'h00;
      s_nxt.tick    = 1'b1;
    end else if (s_r.div_cnt >= div_lim) begin
      s_nxt.div_cnt = 8'h00;
      s_nxt.tick    = 1'b1;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 8'h01;
      s_nxt.tick    = 1'b0;
    end

    // blink timer counts frames; held cleared when blinking is off so nothing shows
    if (!blink_en) begin
      s_nxt.blink_cnt   = 8'h00;
      s_nxt.blink_phase = 1'b0;
    end else if (FRAME_START) begin
      if (s_r.blink_cnt >= s_r.blink_per) begin
        s_nxt.blink_cnt   = 8'h00;
        s_nxt.blink_phase = ~s_r.blink_phase;
      end else begin
        s_nxt.blink_cnt = s_r.blink_cnt + 8'h01;
      end
    end

    // window fetch sequencer; dropping window enable aborts the frame at once
    case (s_r.state)
      dwb_pkg::FETCH_IDLE: begin
        if (FRAME_START & win_en) begin
          s_nxt.state     = dwb_pkg::FETCH_RUN;
          s_nxt.word_cnt  = '0;
          s_nxt.line_cnt  = '0;
          s_nxt.line_base = float_en ? s_r.fstart : s_r.wstart;
          s_nxt.addr      = float_en ? s_r.fstart : s_r.wstart;
        end
      end
      dwb_pkg::FETCH_RUN: begin
        if (!win_en) begin
          s_nxt.state = dwb_pkg::FETCH_IDLE;
        end else if (FETCH_READY) begin
          if (s_r.word_cnt == s_r.width) begin
            s_nxt.word_cnt = '0;
            if (s_r.line_cnt == s_r.height) begin
              s_nxt.state = dwb_pkg::FETCH_IDLE;
              s_nxt.done  = 1'b1;
            end else begin
              s_nxt.line_cnt  = s_r.line_cnt + 10'h001;
              s_nxt.line_base = s_r.line_base + {7'h00, s_r.width} + 16'h0001;
              s_nxt.addr      = s_r.line_base + {7'h00, s_r.width} + 16'h0001;
            end
          end else begin
            s_nxt.word_cnt = s_r.word_cnt + 9'h001;
            s_nxt.addr     = s_r.addr + 16'h0001;
          end
        end
      end
      default: begin
        s_nxt.state = dwb_pkg::FETCH_IDLE;
      end
    endcase

    // pixel path controls line up with the registered table read
    s_nxt.sel_blink = PIX_IN_WIN & blink_en & s_r.blink_phase;
    s_nxt.sel_inv   = PIX_IN_WIN & inv_en;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // every field clears at reset except state, which loads FETCH_IDLE
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_r       <= '0;
      s_r.state <= dwb_pkg::FETCH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // colour tables
  // ****************************************************************
  colour_lookup_table #(
    .ENTRIES (`DWB_LUT_ENTRIES),
    .BITS    (`DWB_LUT_BITS)
  ) u_lut (
    .clk   (CLOCK),
    .we    (LUT_WE),
    .waddr (LUT_WADDR),
    .wdata (LUT_WDATA),
    .raddr (lut_idx),
    .rdata (lut_rgb)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // invert is applied after the table lookup
  assign PIX_RGB     = s_r.sel_inv ? ~lut_rgb : lut_rgb;
  assign RD_DATA     = s_r.rd_data;
  assign CLK_SRC_BUS = s_r.clk_sel[`DWB_CLK_SRC_BIT];
  assign OP_CLK_TICK = s_r.tick;
  assign FETCH_VALID = (s_r.state == dwb_pkg::FETCH_RUN) & win_en;
  assign FETCH_ADDR  = s_r.addr;
  assign FETCH_FLOAT = float_en;
  assign FETCH_DONE  = s_r.done;
  assign BLINK_PHASE = s_r.blink_phase;

endmodule

`default_nettype wire

// [dwb_assertions.sv]
// port checker for the window and blink control block
`timescale 1ns/10ps
`default_nettype none
`include "dwb_params.svh"
module dwb_assertions (
  input wire logic                       CLOCK,        // block clock
  input wire logic                       RSTN,         // reset, active low
  input wire logic                       CS_N,         // select, active low
  input wire logic [`DWB_ADDR_W-1:0]     ADDR,         // byte address
  input wire logic                       WR_STB,       // write strobe
  input wire logic                       RD_STB,       // read strobe
  input wire logic [7:0]                 WR_DATA,      // write byte
  input wire logic [7:0]                 RD_DATA,      // read byte
  input wire logic                       CLK_SRC_BUS,  // clock source
  input wire logic                       OP_CLK_TICK,  // operating tick
  input wire logic                       FRAME_START,  // frame pulse
  input wire logic                       FETCH_VALID,  // fetch request
  input wire logic                       FETCH_READY,  // fetch taken
  input wire logic [`DWB_WADDR_BITS-1:0] FETCH_ADDR,   // fetch word
  input wire logic                       FETCH_DONE,   // fetch finished
  input wire logic                       BLINK_PHASE   // blink colour shown
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  property p_rd_unmapped;
    (!CS_N && RD_STB && (ADDR < `DWB_OFS_WIN_CTRL || ADDR > `DWB_OFS_CLK_SRC_DIV)) |=> RD_DATA == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_width_hi;
    (!CS_N && RD_STB && ADDR == `DWB_OFS_WIDTH_HI) |=> RD_DATA[7:1] == 7'h00;
  endproperty
  a_rd_width_hi: assert property (p_rd_width_hi) else $error("width high spare bits set");
  // written byte comes back; guard against a second write in between
  property p_wr_rd;
    (!CS_N && RD_STB && !WR_STB && ADDR == `DWB_OFS_WSTART_LO && !$past(WR_STB)
     && $past(!CS_N && WR_STB && ADDR == `DWB_OFS_WSTART_LO, 2)) |=> RD_DATA == $past(WR_DATA, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("window start readback wrong");
  property p_clk_src;
    (!CS_N && WR_STB && ADDR == `DWB_OFS_CLK_SRC_DIV) |=> CLK_SRC_BUS == $past(WR_DATA[7]);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source bit wrong");
  property p_tick_input;
    (!CLK_SRC_BUS ##1 !CLK_SRC_BUS) |-> OP_CLK_TICK;
  endproperty
  a_tick_input: assert property (p_tick_input) else $error("tick missing on pin source");
  property p_fetch_step;
    (FETCH_VALID && FETCH_READY ##1 FETCH_VALID) |-> FETCH_ADDR == $past(FETCH_ADDR) + 16'h0001;
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("fetch address not contiguous");
  property p_addr_hold;
    (FETCH_VALID && !FETCH_READY) |=> $stable(FETCH_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved while stalled");
  property p_done;
    FETCH_DONE |-> ($past(FETCH_VALID && FETCH_READY) ##1 !FETCH_DONE);
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_valid_start;
    $rose(FETCH_VALID) |-> $past(FRAME_START);
  endproperty
  a_valid_start: assert property (p_valid_start) else $error("fetch began without frame");
  property p_blink_rise;
    $rose(BLINK_PHASE) |-> $past(FRAME_START);
  endproperty
  a_blink_rise: assert property (p_blink_rise) else $error("blink phase moved without frame");
  c_fetch_done: cover property (FETCH_DONE);
  c_blink: cover property ($rose(BLINK_PHASE));
  c_bus_tick: cover property (CLK_SRC_BUS && OP_CLK_TICK);
endmodule
`default_nettype wire

// [dwb_host.sv]
// host processor model driving the register bus
`timescale 1ns/10ps
`default_nettype none
`include "dwb_params.svh"
module dwb_host (
  input  wire logic                   clk,      // block clock
  output logic                        cs_n,     // select, active low
  output logic [`DWB_ADDR_W-1:0]      addr,     // byte address
  output logic                        wr_stb,   // write strobe
  output logic                        rd_stb,   // read strobe
  output logic [7:0]                  wr_data,  // write byte
  input  wire logic [7:0]             rd_data   // read byte
);
  initial begin
    {cs_n, wr_stb, rd_stb} = 3'h4;
    addr = 17'h00000;
    wr_data = 8'h00;
  end
  // one access; released lines are scrambled so stale values never look valid
  task automatic access(input logic [16:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    @(posedge clk);
    #1;
    {cs_n, wr_stb, rd_stb, addr, wr_data} = {1'b0, w, !w, a, d};
    @(posedge clk);
    #1;
    q = rd_data;
    {cs_n, wr_stb, rd_stb, addr, wr_data} = {3'h4, ~a, ~d};
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [16:0] a, output logic [7:0] q);
    access(a, 8'h00, 1'b0, q);
  endtask
  // size in pixels and lines, spare high bits kept zero
  task automatic set_size(input int px, input int ln);
    logic [15:0] w;
    logic [15:0] h;
    w = 16'(px / 2 - 1);
    h = 16'(ln - 1);
    wr(`DWB_OFS_WIDTH_LO, w[7:0]);
    wr(`DWB_OFS_WIDTH_HI, {7'h00, w[8]});
    wr(`DWB_OFS_HEIGHT_LO, h[7:0]);
    wr(`DWB_OFS_HEIGHT_HI, {6'h00, h[9:8]});
  endtask
endmodule
`default_nettype wire

// [display_window_blink_control_bench.sv]
// self-checking bench for the window and blink control block
`timescale 1ns/10ps
`default_nettype none
`include "dwb_params.svh"
module display_window_blink_control_bench;
  logic        clk, rstn, cs_n, wr_stb, rd_stb, div2, frame, ready, lut_we, in_win;
  logic        src_bus, tick, fvalid, ffloat, fdone, phase;
  logic [16:0] addr;
  logic [7:0]  wr_data, rd_data, lut_waddr, pix_index, q;
  logic [11:0] lut_wdata, pix_rgb;
  logic [15:0] fetch_addr;
  int          failures, compares;
  dwb_host host (.clk(clk), .cs_n(cs_n), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .rd_data(rd_data));
  display_window_blink_control dut (.CLOCK(clk), .RSTN(rstn), .CS_N(cs_n), .ADDR(addr),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .WR_DATA(wr_data), .RD_DATA(rd_data), .CLK_DIV2(div2),
    .CLK_SRC_BUS(src_bus), .OP_CLK_TICK(tick), .FRAME_START(frame), .FETCH_VALID(fvalid),
    .FETCH_READY(ready), .FETCH_ADDR(fetch_addr), .FETCH_FLOAT(ffloat), .FETCH_DONE(fdone),
    .LUT_WE(lut_we), .LUT_WADDR(lut_waddr), .LUT_WDATA(lut_wdata), .PIX_INDEX(pix_index),
    .PIX_IN_WIN(in_win), .PIX_RGB(pix_rgb), .BLINK_PHASE(phase));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse();
    frame = 1'b1;
    step(1);
    frame = 1'b0;
  endtask
  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [7:0] m [12] = '{8'h1b, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff};
    for (int i = 0; i < 12; i++) begin
      host.rd(`DWB_OFS_WIN_CTRL + 17'(i), q);
      chk(16'(q), 16'h0000);
      host.wr(`DWB_OFS_WIN_CTRL + 17'(i), 8'hff);
      host.rd(`DWB_OFS_WIN_CTRL + 17'(i), q);
      chk(16'(q), 16'(m[i]));
    end
    chk(16'(src_bus), 16'h0001);
    host.wr(17'h1ff90, 8'h5a);
    host.rd(17'h1ff90, q);
    chk(16'(q), 16'h0000);
    for (int i = 0; i < 12; i++)
      host.wr(`DWB_OFS_WIN_CTRL + 17'(i), 8'h00);
    $display("test regs done");
  endtask
  task automatic t_fetch();
    host.set_size(4, 2);
    host.wr(`DWB_OFS_WSTART_LO, 8'h10);
    host.wr(`DWB_OFS_FSTART_HI, 8'h02);
    host.wr(`DWB_OFS_WIN_CTRL, 8'h10);
    ready = 1'b1;
    pulse();
    for (int i = 0; i < 4; i++) begin
      chk(16'(fvalid), 16'h0001);
      chk(fetch_addr, 16'h0010 + 16'(i));
      step(1);
    end
    chk(16'(fdone), 16'h0001);
    // floating window, far side stalls first
    host.wr(`DWB_OFS_WIN_CTRL, 8'h18);
    ready = 1'b0;
    pulse();
    step(3);
    chk(16'(ffloat), 16'h0001);
    ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk(fetch_addr, 16'h0200 + 16'(i));
      step(1);
    end
    chk(16'(fdone), 16'h0001);
    // abort a stalled window before its first word by clearing the window bit
    ready = 1'b0;
    pulse();
    chk(16'(fvalid), 16'h0001);
    host.wr(`DWB_OFS_WIN_CTRL, 8'h00);
    chk(16'({fvalid, ffloat}), 16'h0000);
    step(1);
    chk(16'(fdone), 16'h0000);
    $display("test fetch done");
  endtask
  task automatic t_blink();
    {lut_we, lut_waddr, lut_wdata} = {1'b1, 8'h05, 12'h123};
    step(1);
    {lut_waddr, lut_wdata} = {8'h33, 12'habc};
    step(1);
    {lut_we, pix_index, in_win, ready} = {1'b0, 8'h05, 2'h3};
    step(2);
    chk(16'(pix_rgb), 16'h0123);
    host.wr(`DWB_OFS_BLINK_IDX, 8'h33);
    host.wr(`DWB_OFS_BLINK_PER, 8'h01);
    host.wr(`DWB_OFS_WIN_CTRL, 8'h12);
    for (int f = 1; f <= 4; f++) begin
      pulse();
      step(2);
      chk(16'(phase), 16'(f == 2 || f == 3));
      chk(16'(pix_rgb), (f == 2 || f == 3) ? 16'h0abc : 16'h0123);
    end
    host.wr(`DWB_OFS_WIN_CTRL, 8'h11);
    step(2);
    chk(16'(pix_rgb), 16'h0edc);
    in_win = 1'b0;
    step(2);
    chk(16'(pix_rgb), 16'h0123);
    in_win = 1'b1;
    host.wr(`DWB_OFS_WIN_CTRL, 8'h03);
    pulse();
    step(1);
    pulse();
    step(2);
    chk(16'({phase, pix_rgb}), 16'h0123);
    $display("test blink done");
  endtask
  task automatic t_clock();
    int n;
    host.wr(`DWB_OFS_CLK_SRC_DIV, 8'h82);
    for (int k = 0; k < 2; k++) begin
      div2 = k[0];
      step(12);
      n = 0;
      repeat (36) begin
        n += int'(tick);
        step(1);
      end
      chk(16'(n), k ? 16'h0006 : 16'h000c);
    end
    chk(16'(src_bus), 16'h0001);
    host.wr(`DWB_OFS_CLK_SRC_DIV, 8'h00);
    step(2);
    chk(16'(tick), 16'h0001);
    $display("test clock done");
  endtask
  // ****************************************************************
  // clock, main sequence, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rstn, div2, frame, ready, lut_we, in_win} = 6'h00;
    {lut_waddr, lut_wdata, pix_index} = 28'h0000000;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_regs();
    t_fetch();
    t_blink();
    t_clock();
    test_done();
  end
  // whole run is under two thousand cycles
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
bind display_window_blink_control dwb_assertions u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .CS_N(CS_N),
  .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .CLK_SRC_BUS(CLK_SRC_BUS), .OP_CLK_TICK(OP_CLK_TICK), .FRAME_START(FRAME_START),
  .FETCH_VALID(FETCH_VALID), .FETCH_READY(FETCH_READY), .FETCH_ADDR(FETCH_ADDR),
  .FETCH_DONE(FETCH_DONE), .BLINK_PHASE(BLINK_PHASE));
`default_nettype wire
